// *** rtl/brse_evaluator.sv ***
// boolean rung evaluator: contacts, branch combines and coils
`timescale 1ns/100ps
`default_nettype none
module brse_evaluator #(
	parameter int IMG_BITS = 568,
	parameter int NUM_TC = brse_pkg::TC_COUNT
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic instr_valid_i,
	input wire brse_pkg::brse_instr_t instr_i,
	input wire logic scan_end_i,
	input wire logic [NUM_TC-1:0] tmr_done_i,
	input wire logic [NUM_TC-1:0] cnt_done_i,
	input wire logic [IMG_BITS-1:0] input_image_i,
	input wire logic [IMG_BITS-1:0] input_mask_i,
	output logic [IMG_BITS-1:0] image_o,
	output logic [IMG_BITS-1:0] phys_out_o,
	output logic rung_o,
	output logic error_o,
	output brse_pkg::brse_coil_t coil_o
);
	import brse_pkg::*;

	logic [IMG_BITS-1:0] img_q, img_d;
	logic [IMG_BITS-1:0] unm_q, unm_d;
	logic [IMG_BITS-1:0] prev_q, prev_d;
	logic [IMG_BITS-1:0] phys_q, phys_d;
	logic err_q, err_d;
	brse_coil_t coil_q, coil_d;
	logic clr, push, push_val, merge, merge_and, set_top, top_val;
	logic top, ovf, unf;
	logic [3:0] level;
	logic img_bit;
	logic [ADDR_W-1:0] a;
	logic [TC_IDX_W-1:0] tci;

	function automatic logic bit_at(input logic [IMG_BITS-1:0] v, input logic [ADDR_W-1:0] ad);
		bit_at = (int'(ad) < IMG_BITS) ? v[ad] : 1'b0;
	endfunction : bit_at

	brse_stack #(.DEPTH(STACK_DEPTH)) u_stack (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.clear_i(clr),
		.push_i(push),
		.push_val_i(push_val),
		.merge_i(merge),
		.merge_and_i(merge_and),
		.set_top_i(set_top),
		.top_val_i(top_val),
		.top_o(top),
		.overflow_o(ovf),
		.underflow_o(unf),
		.level_o(level)
	);

	assign a = instr_i.addr;
	assign tci = instr_i.addr[TC_IDX_W-1:0];
	assign img_bit = bit_at((img_q & ~input_mask_i) | (input_image_i & input_mask_i), a);

	// contact evaluation, branch combines and rung clear
	always_comb begin
		clr = 1'b0;
		push = 1'b0;
		push_val = 1'b0;
		merge = 1'b0;
		merge_and = 1'b0;
		set_top = 1'b0;
		top_val = top;
		if (instr_valid_i) begin
			case (instr_i.op)
				BRSE_RUNG_START: clr = 1'b1;
				BRSE_BRANCH_START: begin
					push = 1'b1;
					push_val = img_bit;
				end
				BRSE_BRANCH_START_NOT: begin
					push = 1'b1;
					push_val = ~img_bit;
				end
				BRSE_SERIES: begin
					set_top = 1'b1;
					top_val = top & img_bit;
				end
				BRSE_SERIES_NOT: begin
					set_top = 1'b1;
					top_val = top & ~img_bit;
				end
				BRSE_PARALLEL: begin
					set_top = 1'b1;
					top_val = top | img_bit;
				end
				BRSE_PARALLEL_NOT: begin
					set_top = 1'b1;
					top_val = top | ~img_bit;
				end
				BRSE_SERIES_TMR: begin
					set_top = 1'b1;
					top_val = top & tmr_done_i[tci];
				end
				BRSE_SERIES_NOT_TMR: begin
					set_top = 1'b1;
					top_val = top & ~tmr_done_i[tci];
				end
				BRSE_SERIES_CNT: begin
					set_top = 1'b1;
					top_val = top & cnt_done_i[tci];
				end
				BRSE_SERIES_NOT_CNT: begin
					set_top = 1'b1;
					top_val = top & ~cnt_done_i[tci];
				end
				BRSE_BRANCH_SERIES_COMBINE: begin
					merge = 1'b1;
					merge_and = 1'b1;
				end
				BRSE_BRANCH_PARALLEL_COMBINE: merge = 1'b1;
				default: ;
			endcase
		end
	end

	// coil execution and output image
	always_comb begin
		img_d = img_q;
		unm_d = unm_q;
		prev_d = prev_q;
		phys_d = phys_q;
		err_d = err_q | ovf | unf;
		coil_d = '0;
		if (instr_valid_i && int'(a) < IMG_BITS) begin
			case (instr_i.op)
				BRSE_COIL_OUT: begin
					img_d[a] = top;
					unm_d[a] = 1'b0;
					coil_d = '{1'b1, a, top, 1'b0};
				end
				BRSE_COIL_UNMASKED: begin
					img_d[a] = top;
					unm_d[a] = 1'b1;
					coil_d = '{1'b1, a, top, 1'b1};
				end
				BRSE_COIL_LATCH: begin
					if (top) begin
						img_d[a] = 1'b1;
					end
					unm_d[a] = 1'b0;
					coil_d = '{1'b1, a, img_d[a], 1'b0};
				end
				BRSE_COIL_UNLATCH: begin
					if (top) begin
						img_d[a] = 1'b0;
					end
					unm_d[a] = 1'b0;
					coil_d = '{1'b1, a, img_d[a], 1'b0};
				end
				BRSE_COIL_ONE_SHOT: begin
					img_d[a] = top & ~prev_q[a];
					prev_d[a] = top;
					unm_d[a] = 1'b0;
					coil_d = '{1'b1, a, img_d[a], 1'b0};
				end
				default: ;
			endcase
		end
		if (scan_end_i) begin
			// last write of the scan reaches the pins unless image bit OUT_DISABLE_ADDR is set and the coil is masked
			for (int i = 0; i < IMG_BITS; i++) begin
				phys_d[i] = img_d[i] & (unm_d[i] | ~img_d[OUT_DISABLE_ADDR]);
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			img_q <= '0;
			unm_q <= '0;
			prev_q <= '0;
			phys_q <= '0;
			err_q <= 1'b0;
			coil_q <= '0;
		end else begin
			img_q <= img_d;
			unm_q <= unm_d;
			prev_q <= prev_d;
			phys_q <= phys_d;
			err_q <= err_d;
			coil_q <= coil_d;
		end
	end

	assign image_o = img_q;
	assign phys_out_o = phys_q;
	assign rung_o = top;
	assign error_o = err_q;
	assign coil_o = coil_q;

	out_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(instr_valid_i && instr_i.op == BRSE_COIL_OUT && int'(a) < IMG_BITS)
		|=> img_q[$past(a)] == $past(top)) else $error("plain coil not written");
	latch_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(instr_valid_i && instr_i.op == BRSE_COIL_LATCH && top && int'(a) < IMG_BITS)
		|=> img_q[$past(a)]) else $error("latch did not set");
	unlatch_clr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(instr_valid_i && instr_i.op == BRSE_COIL_UNLATCH && top && int'(a) < IMG_BITS)
		|=> !img_q[$past(a)]) else $error("unlatch did not clear");
	one_shot_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(instr_valid_i && instr_i.op == BRSE_COIL_ONE_SHOT && int'(a) < IMG_BITS)
		|=> img_q[$past(a)] == ($past(top) & ~$past(prev_q[a])))
		else $error("one shot wrong");
	tmr_not_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(instr_valid_i && instr_i.op == BRSE_SERIES_NOT_TMR && level != 4'h0)
		|=> top == ($past(top) & ~$past(tmr_done_i[tci])))
		else $error("negated timer contact wrong");
	cnt_ser_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(instr_valid_i && instr_i.op == BRSE_SERIES_CNT && level != 4'h0)
		|=> top == ($past(top) & $past(cnt_done_i[tci])))
		else $error("counter contact wrong");
	err_sticky_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(ovf || unf) |=> error_o) else $error("stack error not flagged");
endmodule : brse_evaluator
`default_nettype wire

// *** rtl/brse_pkg.sv ***
// package for the boolean rung stack evaluator
package brse_pkg;
	localparam int ADDR_W = 10;
	localparam int STACK_DEPTH = 8;
	localparam int TC_IDX_W = 6;
	localparam int TC_COUNT = 64;
	localparam int VAL_W = 14;
	localparam logic [ADDR_W-1:0] OUT_DISABLE_ADDR = 10'h0fe;
	localparam logic [ADDR_W-1:0] IMAGE_BITS = 10'h238;

	typedef enum logic [4:0] {
		BRSE_NOP = 5'h00,
		BRSE_BRANCH_START = 5'h01,
		BRSE_BRANCH_START_NOT = 5'h02,
		BRSE_SERIES = 5'h03,
		BRSE_SERIES_NOT = 5'h04,
		BRSE_PARALLEL = 5'h05,
		BRSE_PARALLEL_NOT = 5'h06,
		BRSE_SERIES_TMR = 5'h07,
		BRSE_SERIES_NOT_TMR = 5'h08,
		BRSE_SERIES_CNT = 5'h09,
		BRSE_SERIES_NOT_CNT = 5'h0a,
		BRSE_BRANCH_SERIES_COMBINE = 5'h0b,
		BRSE_BRANCH_PARALLEL_COMBINE = 5'h0c,
		BRSE_COIL_OUT = 5'h0d,
		BRSE_COIL_LATCH = 5'h0e,
		BRSE_COIL_UNLATCH = 5'h0f,
		BRSE_COIL_UNMASKED = 5'h10,
		BRSE_COIL_ONE_SHOT = 5'h11,
		BRSE_RUNG_START = 5'h12
	} brse_op_t;

	typedef struct packed {
		brse_op_t op;
		logic [ADDR_W-1:0] addr;
	} brse_instr_t;

	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic value;
		logic unmasked;
	} brse_coil_t;
endpackage : brse_pkg

// *** rtl/brse_stack.sv ***
// eight-level logic stack with push and merge
`timescale 1ns/100ps
`default_nettype none
module brse_stack #(
	parameter int DEPTH = brse_pkg::STACK_DEPTH
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic clear_i,
	input wire logic push_i,
	input wire logic push_val_i,
	input wire logic merge_i,
	input wire logic merge_and_i,
	input wire logic set_top_i,
	input wire logic top_val_i,
	output logic top_o,
	output logic overflow_o,
	output logic underflow_o,
	output logic [3:0] level_o
);
	import brse_pkg::*;
	logic [DEPTH-1:0] st_q, st_d;
	logic [3:0] lvl_q, lvl_d;

	always_comb begin
		st_d = st_q;
		lvl_d = lvl_q;
		overflow_o = 1'b0;
		underflow_o = 1'b0;
		if (clear_i) begin
			lvl_d = 4'h0;
		end else if (push_i) begin
			if (lvl_q == 4'(DEPTH)) begin
				overflow_o = 1'b1;
			end else begin
				st_d = {st_q[DEPTH-2:0], push_val_i};
				lvl_d = lvl_q + 4'h1;
			end
		end else if (merge_i) begin
			if (lvl_q < 4'h2) begin
				underflow_o = 1'b1;
			end else begin
				st_d = {1'b0, st_q[DEPTH-1:1]};
				st_d[0] = merge_and_i ? (st_q[0] & st_q[1]) : (st_q[0] | st_q[1]);
				lvl_d = lvl_q - 4'h1;
			end
		end else if (set_top_i) begin
			if (lvl_q == 4'h0) begin
				underflow_o = 1'b1;
			end else begin
				st_d[0] = top_val_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q <= '0;
			lvl_q <= 4'h0;
		end else begin
			st_q <= st_d;
			lvl_q <= lvl_d;
		end
	end

	assign top_o = st_q[0];
	assign level_o = lvl_q;

	depth_bound_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		lvl_q <= 4'(DEPTH)) else $error("stack level above depth");
	push_shift_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(push_i && !clear_i && lvl_q < 4'(DEPTH)) |=> (st_q[0] == $past(push_val_i)
		&& st_q[1] == $past(st_q[0]) && lvl_q == $past(lvl_q) + 4'h1))
		else $error("push did not shift stack");
	merge_and_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(merge_i && merge_and_i && !clear_i && !push_i && lvl_q >= 4'h2)
		|=> (st_q[0] == ($past(st_q[0]) & $past(st_q[1])) && lvl_q == $past(lvl_q) - 4'h1))
		else $error("series combine wrong");
	merge_or_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(merge_i && !merge_and_i && !clear_i && !push_i && lvl_q >= 4'h2)
		|=> (st_q[0] == ($past(st_q[0]) | $past(st_q[1])) && lvl_q == $past(lvl_q) - 4'h1))
		else $error("parallel combine wrong");
	overflow_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(push_i && !clear_i && lvl_q == 4'(DEPTH)) |-> overflow_o ##1 lvl_q == 4'(DEPTH))
		else $error("overflow not flagged");
	clear_empty_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		clear_i |=> lvl_q == 4'h0) else $error("stack not cleared");
endmodule : brse_stack
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the rung evaluator
`timescale 1ns/100ps
`default_nettype none
module tb;
	import brse_pkg::*;
	typedef struct packed {
		logic [9:0] sa;
		brse_op_t op;
		logic [9:0] a;
		logic e;
	} brse_row_t;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic instr_valid_i = 1'b0;
	brse_instr_t instr_i = '0;
	logic scan_end_i = 1'b0;
	logic [63:0] tmr_done_i = 64'h10;
	logic [63:0] cnt_done_i = 64'h4;
	logic [567:0] input_image_i = 568'h5;
	logic [567:0] input_mask_i = 568'hff;
	logic [567:0] image_o;
	logic [567:0] phys_out_o;
	logic rung_o;
	logic error_o;
	brse_coil_t coil_o;
	int err_total = 0;
	int n_checks = 0;
	brse_row_t rows [14] = '{
		'{10'h1, BRSE_PARALLEL, 10'h2, 1'b1},
		'{10'h1, BRSE_PARALLEL_NOT, 10'h2, 1'b0},
		'{10'h1, BRSE_PARALLEL, 10'h1, 1'b0},
		'{10'h0, BRSE_SERIES, 10'h1, 1'b0},
		'{10'h0, BRSE_SERIES_NOT, 10'h1, 1'b1},
		'{10'h0, BRSE_SERIES_TMR, 10'h4, 1'b1},
		'{10'h0, BRSE_SERIES_TMR, 10'h5, 1'b0},
		'{10'h0, BRSE_SERIES_NOT_TMR, 10'h5, 1'b1},
		'{10'h0, BRSE_SERIES_NOT_TMR, 10'h4, 1'b0},
		'{10'h0, BRSE_SERIES_CNT, 10'h2, 1'b1},
		'{10'h0, BRSE_SERIES_CNT, 10'h3, 1'b0},
		'{10'h0, BRSE_SERIES_NOT_CNT, 10'h3, 1'b1},
		'{10'h0, BRSE_SERIES_NOT_CNT, 10'h2, 1'b0},
		'{10'h1, BRSE_BRANCH_START_NOT, 10'h1, 1'b1}
	};

	brse_evaluator dut (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.scan_end_i(scan_end_i),
		.tmr_done_i(tmr_done_i),
		.cnt_done_i(cnt_done_i),
		.input_image_i(input_image_i),
		.input_mask_i(input_mask_i),
		.image_o(image_o),
		.phys_out_o(phys_out_o),
		.rung_o(rung_o),
		.error_o(error_o),
		.coil_o(coil_o)
	);

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic chk(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : chk

	task automatic chk_coil(input brse_coil_t got, input brse_coil_t exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: coil event", $time);
		end
	endtask : chk_coil

	task automatic ex(input brse_op_t op, input logic [9:0] a);
		@(posedge clk_i);
		#1;
		instr_valid_i = 1'b1;
		instr_i.op = op;
		instr_i.addr = a;
	endtask : ex

	task automatic idle();
		@(posedge clk_i);
		#1;
		instr_valid_i = 1'b0;
		scan_end_i = 1'b0;
	endtask : idle

	task automatic scan();
		@(posedge clk_i);
		#1;
		instr_valid_i = 1'b0;
		scan_end_i = 1'b1;
		idle();
	endtask : scan

	task automatic start(input logic [9:0] a);
		ex(BRSE_RUNG_START, 10'h0);
		ex(BRSE_BRANCH_START, a);
	endtask : start

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		$display("unexpected at %0t: run too long", $time);
		results();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		chk(rung_o | error_o | coil_o.valid | (|image_o) | (|phys_out_o), 1'b0, "reset");
		nrst_i = 1'b1;
		foreach (rows[i]) begin
			start(rows[i].sa);
			ex(rows[i].op, rows[i].a);
			ex(BRSE_COIL_OUT, 10'h8);
			idle();
			chk(rung_o, rows[i].e, "contact row");
			chk(image_o[8], rows[i].e, "coil row");
		end
		$display("contact table done");
		start(10'h0);
		ex(BRSE_BRANCH_START, 10'h1);
		idle();
		chk(rung_o, 1'b0, "push top");
		ex(BRSE_BRANCH_PARALLEL_COMBINE, 10'h0);
		idle();
		chk(rung_o, 1'b1, "or combine");
		start(10'h0);
		ex(BRSE_BRANCH_START, 10'h1);
		ex(BRSE_BRANCH_SERIES_COMBINE, 10'h0);
		idle();
		chk(rung_o, 1'b0, "and combine");
		$display("combine test done");
		start(10'h0);
		ex(BRSE_COIL_OUT, 10'hc);
		start(10'h1);
		ex(BRSE_COIL_OUT, 10'hc);
		scan();
		chk(phys_out_o[12], 1'b0, "last coil wins");
		start(10'h0);
		ex(BRSE_COIL_LATCH, 10'h14);
		start(10'h1);
		ex(BRSE_COIL_LATCH, 10'h14);
		ex(BRSE_COIL_UNLATCH, 10'h14);
		idle();
		chk(image_o[20], 1'b1, "latch hold");
		start(10'h0);
		ex(BRSE_COIL_UNLATCH, 10'h14);
		start(10'h1);
		ex(BRSE_COIL_LATCH, 10'h14);
		idle();
		chk(image_o[20], 1'b0, "unlatch hold");
		$display("coil test done");
		start(10'h0);
		ex(BRSE_COIL_OUT, OUT_DISABLE_ADDR);
		ex(BRSE_COIL_OUT, 10'h9);
		ex(BRSE_COIL_UNMASKED, 10'ha);
		idle();
		chk_coil(coil_o, '{1'b1, 10'ha, 1'b1, 1'b1});
		scan();
		chk(image_o[9], 1'b1, "masked image");
		chk(phys_out_o[9], 1'b0, "masked output");
		chk(phys_out_o[10], 1'b1, "unmasked output");
		$display("output disable test done");
		for (int s = 0; s < 4; s++) begin
			start((s == 1 || s == 2) ? 10'h0 : 10'h1);
			ex(BRSE_COIL_ONE_SHOT, 10'h1e);
			scan();
			chk(image_o[30], s == 1, "one shot");
		end
		$display("one shot test done");
		for (int r = 0; r < 2; r++) begin
			ex(BRSE_RUNG_START, 10'h0);
			repeat (8) begin
				ex(BRSE_BRANCH_START, 10'h0);
				ex(BRSE_SERIES, 10'h0);
			end
		end
		idle();
		chk(error_o, 1'b0, "eight levels");
		ex(BRSE_BRANCH_START, 10'h0);
		idle();
		chk(error_o, 1'b1, "ninth level");
		nrst_i = 1'b0;
		idle();
		chk(error_o | rung_o | (|image_o), 1'b0, "second reset");
		nrst_i = 1'b1;
		start(10'h0);
		ex(BRSE_BRANCH_SERIES_COMBINE, 10'h0);
		idle();
		chk(error_o, 1'b1, "combine underflow");
		$display("stack error test done");
		results();
	end
endmodule : tb
`default_nettype wire
